// ===== verilog/vsc_pkg.sv
// Shared constants and types for the vision sensor control/status port
package vsc_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SWITCH_MS = 150;
  localparam int SWITCH_CYCLES = SWITCH_MS * 1000000 / CLK_PERIOD_NS;
  localparam int DEBOUNCE_MS = 10;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * 1000000 / CLK_PERIOD_NS;
  // Control byte bit positions
  localparam int CTL_EXT_EN = 0;
  localparam int CTL_PICK_LO = 1;
  localparam int CTL_PICK_HI = 4;
  localparam int CTL_CAPTURE = 6;
  localparam int CTL_ERR_CLR = 7;
  // Status byte bit positions
  localparam int STS_OPER = 0;
  localparam int STS_TRAINED = 1;
  localparam int STS_READY = 2;
  localparam int STS_GOOD = 3;
  localparam int STS_BAD = 5;
  // Models and data areas
  localparam logic [3:0] MODEL_NONE = 4'h0;
  localparam int MODEL_MAX = 15;
  localparam int SEND_BYTES = 32;
  localparam int RECV_BYTES = 10;
  localparam int DELAY_FIRST = 6;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  typedef enum logic [2:0] {
    SW_NONE,
    SW_START,
    SW_LOAD,
    SW_UNTRAINED,
    SW_RUN
  } vsc_sw_state_e;
endpackage : vsc_pkg

// ===== verilog/vsc_sync2.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module vsc_sync2 #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Asynchronous input and synchronised copy
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      meta <= '0;
      q_o <= '0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule : vsc_sync2

// ===== verilog/vsc_pulse_hold.sv
// Stretches a one-cycle event to a fixed pulse length
`timescale 1ns/10ps
module vsc_pulse_hold #(
  parameter int CYCLES = 1000000
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Event in, held pulse out
  input wire logic event_i,
  output logic hold_o
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES);
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;

  assign next_count = event_i ? LOAD :
                      (count != '0) ? count - 1'b1 : count;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      count <= '0;
      hold_o <= 1'b0;
    end else begin
      count <= next_count;
      hold_o <= next_count != '0;
    end
  end
endmodule : vsc_pulse_hold

// ===== verilog/vsc_ctrl_port.sv
// Control and status byte interpreter with model switchover sequencing
`timescale 1ns/10ps
module vsc_ctrl_port #(
  parameter int SWITCH_CYCLES = vsc_pkg::SWITCH_CYCLES,
  parameter int DEBOUNCE_CYCLES = vsc_pkg::DEBOUNCE_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Discrete control pins and status pins
  input wire logic [7:0] disc_ctrl_i,
  output logic [7:0] disc_status_o,
  // Fieldbus control and status bytes
  input wire logic fb_select_i,
  input wire logic [7:0] fb_ctrl_i,
  output logic [7:0] fb_status_o,
  // Fieldbus incoming data area
  input wire logic fb_wr_i,
  input wire logic [7:0] fb_wr_addr_i,
  input wire logic [7:0] fb_wr_data_i,
  output logic [31:0] trigger_delay_o,
  // Fieldbus outgoing data area
  input wire logic [7:0] fb_rd_addr_i,
  output logic [7:0] fb_rd_data_o,
  // Outgoing area fill from the image processor
  input wire logic snd_wr_i,
  input wire logic [7:0] snd_addr_i,
  input wire logic [7:0] snd_data_i,
  // Manual keypad
  input wire logic keypad_valid_i,
  input wire logic [3:0] keypad_pick_i,
  // Unit state from the processor
  input wire logic startup_done_i,
  input wire logic stop_i,
  input wire logic error_event_i,
  input wire logic [15:0] trained_mask_i,
  input wire logic load_done_i,
  input wire logic result_good_i,
  input wire logic result_bad_i,
  // Commands to the processor
  output logic [3:0] model_o,
  output logic load_req_o,
  output logic capture_o,
  output logic error_clear_o
);
  localparam int TW = $clog2(SWITCH_CYCLES + 1);
  localparam logic [TW-1:0] T_DONE = TW'(SWITCH_CYCLES - 1);
  localparam logic [7:0] BYTE_ZERO = vsc_pkg::BYTE_RESET;

  ////////////////////////////////////////////////////////////////////////////
  // Input capture
  logic [7:0] disc_sync;
  logic [7:0] disc_prev;
  logic [7:0] fb_prev;
  logic [3:0] pick_prev;

  vsc_sync2 #(
    .WIDTH(8)
  ) u_disc_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .d_i(disc_ctrl_i),
    .q_o(disc_sync)
  );

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      disc_prev <= vsc_pkg::CTRL_RESET;
      fb_prev <= vsc_pkg::CTRL_RESET;
    end else begin
      disc_prev <= disc_sync;
      fb_prev <= fb_ctrl_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode
  wire disc_cap_edge;
  wire fb_cap_edge;
  wire disc_clr_edge;
  wire fb_clr_edge;
  wire clr_any;
  wire cap_any;
  assign disc_cap_edge = disc_sync[vsc_pkg::CTL_CAPTURE] &
                         ~disc_prev[vsc_pkg::CTL_CAPTURE];
  assign fb_cap_edge = fb_ctrl_i[vsc_pkg::CTL_CAPTURE] &
                       ~fb_prev[vsc_pkg::CTL_CAPTURE];
  assign disc_clr_edge = disc_sync[vsc_pkg::CTL_ERR_CLR] &
                         ~disc_prev[vsc_pkg::CTL_ERR_CLR];
  assign fb_clr_edge = fb_ctrl_i[vsc_pkg::CTL_ERR_CLR] &
                       ~fb_prev[vsc_pkg::CTL_ERR_CLR];
  assign clr_any = disc_clr_edge | fb_clr_edge;
  assign cap_any = disc_cap_edge | fb_cap_edge;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      capture_o <= 1'b0;
      error_clear_o <= 1'b0;
    end else begin
      capture_o <= cap_any;
      error_clear_o <= clr_any;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Model selection
  wire [7:0] act_ctrl;
  wire ext_en;
  wire [3:0] pick;
  wire pick_stable;
  wire ext_req;
  wire key_req;
  wire sel_req;
  wire [3:0] sel_model;
  logic [3:0] applied;

  assign act_ctrl = fb_select_i ? fb_ctrl_i : disc_sync;
  assign ext_en = act_ctrl[vsc_pkg::CTL_EXT_EN];
  // Bit 5 is never looked at
  assign pick = act_ctrl[vsc_pkg::CTL_PICK_HI:
                         vsc_pkg::CTL_PICK_LO];
  assign pick_stable = pick == pick_prev;
  assign ext_req = ext_en & pick_stable &
                   (pick != vsc_pkg::MODEL_NONE) &
                   (pick != applied);
  assign key_req = ~ext_en & keypad_valid_i &
                   (keypad_pick_i != vsc_pkg::MODEL_NONE) &
                   (keypad_pick_i != applied);
  assign sel_req = ext_req | key_req;
  assign sel_model = ext_req ? pick : keypad_pick_i;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pick_prev <= vsc_pkg::MODEL_NONE;
    end else begin
      pick_prev <= pick;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      applied <= vsc_pkg::MODEL_NONE;
    end else if (sel_req) begin
      applied <= sel_model;
    end
  end

  assign model_o = applied;

  ////////////////////////////////////////////////////////////////////////////
  // Switchover sequence
  vsc_pkg::vsc_sw_state_e state;
  vsc_pkg::vsc_sw_state_e next_state;
  logic [TW-1:0] timer;
  wire timer_done;
  wire model_ok;

  assign timer_done = timer == T_DONE;
  assign model_ok = trained_mask_i[applied];

  always_comb begin
    next_state = state;
    unique case (state)
      vsc_pkg::SW_NONE,
      vsc_pkg::SW_RUN,
      vsc_pkg::SW_UNTRAINED: begin
        if (sel_req) begin
          next_state = vsc_pkg::SW_START;
        end
      end
      vsc_pkg::SW_START: begin
        if (sel_req) begin
          next_state = vsc_pkg::SW_START;
        end else if (timer_done && model_ok) begin
          next_state = vsc_pkg::SW_LOAD;
        end else if (timer_done) begin
          next_state = vsc_pkg::SW_UNTRAINED;
        end
      end
      vsc_pkg::SW_LOAD: begin
        if (sel_req) begin
          next_state = vsc_pkg::SW_START;
        end else if (load_done_i) begin
          next_state = vsc_pkg::SW_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state <= vsc_pkg::SW_NONE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      timer <= '0;
    end else if (sel_req || state != vsc_pkg::SW_START) begin
      timer <= '0;
    end else if (!timer_done) begin
      timer <= timer + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      load_req_o <= 1'b0;
    end else begin
      load_req_o <= state == vsc_pkg::SW_START &&
                    next_state == vsc_pkg::SW_LOAD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error state
  logic err_pending;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      err_pending <= 1'b0;
    end else if (error_event_i) begin
      err_pending <= 1'b1;
    end else if (clr_any) begin
      err_pending <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result pulses
  logic good_hold;
  logic bad_hold;

  vsc_pulse_hold #(
    .CYCLES(DEBOUNCE_CYCLES)
  ) u_good_hold (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .event_i(result_good_i),
    .hold_o(good_hold)
  );

  vsc_pulse_hold #(
    .CYCLES(DEBOUNCE_CYCLES)
  ) u_bad_hold (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .event_i(result_bad_i),
    .hold_o(bad_hold)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Status bytes
  wire trained_now;
  wire ready_now;
  wire [7:0] next_disc_status;
  wire [7:0] next_fb_status;

  assign trained_now = state == vsc_pkg::SW_LOAD ||
                       state == vsc_pkg::SW_RUN;
  assign ready_now = state == vsc_pkg::SW_RUN && startup_done_i &&
                     !stop_i;

  generate
    for (genvar b = 0; b < 8; b++) begin : g_sts
      if (b == vsc_pkg::STS_OPER) begin : g_oper
        assign next_disc_status[b] = ~err_pending;
        assign next_fb_status[b] = ~err_pending & startup_done_i;
      end else if (b == vsc_pkg::STS_TRAINED) begin : g_trn
        assign next_disc_status[b] = trained_now;
        assign next_fb_status[b] = trained_now;
      end else if (b == vsc_pkg::STS_READY) begin : g_rdy
        assign next_disc_status[b] = ready_now;
        assign next_fb_status[b] = ready_now;
      end else if (b == vsc_pkg::STS_GOOD) begin : g_good
        assign next_disc_status[b] = good_hold;
        assign next_fb_status[b] = good_hold;
      end else if (b == vsc_pkg::STS_BAD) begin : g_bad
        assign next_disc_status[b] = bad_hold;
        assign next_fb_status[b] = bad_hold;
      end else begin : g_zero
        assign next_disc_status[b] = 1'b0;
        assign next_fb_status[b] = 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      disc_status_o <= BYTE_ZERO;
      fb_status_o <= BYTE_ZERO;
    end else begin
      disc_status_o <= next_disc_status;
      fb_status_o <= next_fb_status;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fieldbus incoming area
  logic [7:0] recv_area [vsc_pkg::RECV_BYTES];

  generate
    for (genvar i = 0; i < vsc_pkg::RECV_BYTES; i++) begin : g_recv
      always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
          recv_area[i] <= BYTE_ZERO;
        end else if (fb_wr_i && fb_wr_addr_i == 8'(i)) begin
          recv_area[i] <= fb_wr_data_i;
        end
      end
    end
  endgenerate

  // Delay word, most significant byte first
  assign trigger_delay_o = {recv_area[vsc_pkg::DELAY_FIRST],
                            recv_area[vsc_pkg::DELAY_FIRST + 1],
                            recv_area[vsc_pkg::DELAY_FIRST + 2],
                            recv_area[vsc_pkg::DELAY_FIRST + 3]};

  ////////////////////////////////////////////////////////////////////////////
  // Fieldbus outgoing area
  logic [7:0] send_area [vsc_pkg::SEND_BYTES];
  wire rd_in_range;

  assign rd_in_range = fb_rd_addr_i < 8'(vsc_pkg::SEND_BYTES);

  generate
    for (genvar i = 0; i < vsc_pkg::SEND_BYTES; i++) begin : g_send
      always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
          send_area[i] <= BYTE_ZERO;
        end else if (snd_wr_i && snd_addr_i == 8'(i)) begin
          send_area[i] <= snd_data_i;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      fb_rd_data_o <= BYTE_ZERO;
    end else if (rd_in_range) begin
      fb_rd_data_o <= send_area[fb_rd_addr_i[4:0]];
    end else begin
      fb_rd_data_o <= BYTE_ZERO;
    end
  end
endmodule : vsc_ctrl_port

// ===== sim/vsc_ctrl_monitor.sv
// Assertion checker for the control and status port
`timescale 1ns/10ps
module vsc_ctrl_monitor #(
  parameter int SWITCH_CYCLES = 20,
  parameter int DEBOUNCE_CYCLES = 5
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Watched ports
  input wire logic [7:0] fb_ctrl_i,
  input wire logic [7:0] disc_status_o,
  input wire logic [7:0] fb_status_o,
  input wire logic startup_done_i,
  input wire logic [15:0] trained_mask_i,
  input wire logic result_good_i,
  input wire logic result_bad_i,
  input wire logic [3:0] model_o,
  input wire logic capture_o,
  input wire logic error_clear_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  AST_RSV: assert property (
    {disc_status_o[7:6], disc_status_o[4], fb_status_o[7:6],
     fb_status_o[4]} == 6'h00)
    else $error("reserved status bit set");
  AST_CAP: assert property (
    $rose(fb_ctrl_i[6]) |=> capture_o)
    else $error("capture pulse missing");
  AST_CLR: assert property (
    $rose(fb_ctrl_i[7]) |=> error_clear_o)
    else $error("error clear pulse missing");
  AST_GOOD: assert property (
    result_good_i |-> ##2 fb_status_o[3] [*5])
    else $error("good pulse too short");
  AST_BAD: assert property (
    result_bad_i |-> ##2 disc_status_o[5] [*5])
    else $error("bad pulse missing");
  AST_OPER: assert property (
    !startup_done_i |=> !fb_status_o[0])
    else $error("operational during startup");
  AST_TRD: assert property (
    $stable(model_o) && fb_status_o[1] |-> trained_mask_i[model_o])
    else $error("trained shown for untrained model");
  AST_RANGE: assert property (
    $changed(model_o) |-> model_o != 4'h0)
    else $error("model zero applied");
  AST_DROP: assert property (
    $changed(model_o) |=> fb_status_o[2:1] == 2'b00)
    else $error("trained or ready not dropped");
  AST_READY: assert property (
    $rose(fb_status_o[2]) |-> fb_status_o[1])
    else $error("ready before trained");
endmodule : vsc_ctrl_monitor

bind vsc_ctrl_port vsc_ctrl_monitor #(
  .SWITCH_CYCLES(SWITCH_CYCLES),
  .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
) vsc_ctrl_monitor_i (
  .ref_clk_i, .rst_i, .fb_ctrl_i, .disc_status_o, .fb_status_o,
  .startup_done_i, .trained_mask_i, .result_good_i, .result_bad_i,
  .model_o, .capture_o, .error_clear_o
);

// ===== sim/vsc_plc_model.sv
// Controller model driving control bytes and the incoming data area
`timescale 1ns/10ps
module vsc_plc_model (
  // Clock
  input wire logic ref_clk_i,
  // Control bytes and incoming area
  output logic [7:0] disc_ctrl_o,
  output logic fb_select_o,
  output logic [7:0] fb_ctrl_o,
  output logic fb_wr_o,
  output logic [7:0] fb_wr_addr_o,
  output logic [7:0] fb_wr_data_o
);
  initial begin
    disc_ctrl_o = 8'h00;
    fb_select_o = 1'b0;
    fb_ctrl_o = 8'h00;
    fb_wr_o = 1'b0;
    fb_wr_addr_o = 8'h00;
    fb_wr_data_o = 8'h00;
  end

  // Level control byte on the chosen interface
  task automatic put(input logic fb, input logic [7:0] b);
    @(posedge ref_clk_i);
    #1;
    fb_select_o = fb;
    if (fb) begin
      fb_ctrl_o = b;
    end else begin
      disc_ctrl_o = b;
    end
  endtask : put

  // One incoming area byte, data inverted once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    #1;
    fb_wr_o = 1'b1;
    fb_wr_addr_o = a;
    fb_wr_data_o = d;
    @(posedge ref_clk_i);
    #1;
    fb_wr_o = 1'b0;
    fb_wr_data_o = ~d;
  endtask : wr
endmodule : vsc_plc_model

// ===== sim/testbench.sv
// Self-checking testbench for the control and status port
`timescale 1ns/10ps
module testbench;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] disc_ctrl, fb_ctrl, fb_wr_addr, fb_wr_data;
  logic fb_select, fb_wr, capture, err_clr, load_req;
  logic [7:0] disc_status, fb_status, fb_rd_data;
  logic [7:0] fb_rd_addr = 8'h00, snd_addr = 8'h00, snd_data = 8'h00;
  logic snd_wr = 1'b0, keypad_valid = 1'b0, startup_done = 1'b0;
  logic stop = 1'b0, err_ev = 1'b0, load_done = 1'b0;
  logic good = 1'b0, bad = 1'b0;
  logic [3:0] keypad_pick = 4'h9, model;
  logic [15:0] mask = 16'h0802;
  logic [31:0] tdelay;
  int n_mismatch = 0, comparisons = 0, k = 0, n = 0, n_load = 0;

  always #5 ref_clk_i = ~ref_clk_i;

  // Load request pulses, counted mid-cycle
  always @(negedge ref_clk_i) begin
    if (load_req === 1'b1) begin
      n_load++;
    end
  end

  vsc_plc_model vsc_plc_model_i (.ref_clk_i(ref_clk_i),
    .disc_ctrl_o(disc_ctrl), .fb_select_o(fb_select), .fb_ctrl_o(fb_ctrl),
    .fb_wr_o(fb_wr), .fb_wr_addr_o(fb_wr_addr), .fb_wr_data_o(fb_wr_data));

  vsc_ctrl_port #(.SWITCH_CYCLES(20), .DEBOUNCE_CYCLES(5)) vsc_ctrl_port_i (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .disc_ctrl_i(disc_ctrl),
    .disc_status_o(disc_status), .fb_select_i(fb_select),
    .fb_ctrl_i(fb_ctrl), .fb_status_o(fb_status), .fb_wr_i(fb_wr),
    .fb_wr_addr_i(fb_wr_addr), .fb_wr_data_i(fb_wr_data),
    .trigger_delay_o(tdelay), .fb_rd_addr_i(fb_rd_addr),
    .fb_rd_data_o(fb_rd_data), .snd_wr_i(snd_wr), .snd_addr_i(snd_addr),
    .snd_data_i(snd_data), .keypad_valid_i(keypad_valid),
    .keypad_pick_i(keypad_pick), .startup_done_i(startup_done),
    .stop_i(stop), .error_event_i(err_ev), .trained_mask_i(mask),
    .load_done_i(load_done), .result_good_i(good), .result_bad_i(bad),
    .model_o(model), .load_req_o(load_req), .capture_o(capture),
    .error_clear_o(err_clr));

  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int c);
    repeat (c) @(posedge ref_clk_i);
    #1;
  endtask : tick

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  // Bounded wait on one status bit
  task automatic wait_sts(input int b, input logic v);
    for (k = 0; k < 100 && fb_status[b] !== v; k++) tick(1);
    if (k == 100) begin
      n_mismatch++;
      $display("[ERR] %0t timeout %h exp %h", $time, fb_status, v);
      end_sim();
    end
  endtask : wait_sts

  // Count high samples of one output over eight cycles
  task automatic cnt(input int sel);
    n = 0;
    repeat (8) begin
      case (sel)
        0: n += int'(capture === 1'b1);
        1: n += int'(err_clr === 1'b1);
        2: n += int'(fb_status[3] === 1'b1);
        default: n += int'(fb_status[5] === 1'b1);
      endcase
      tick(1);
    end
  endtask : cnt

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(16);
    rst_i = 1'b0;
    tick(4);
    chk(fb_status, 8'h00);
    chk(disc_status, 8'h01);
    startup_done = 1'b1;
    tick(4);
    chk(fb_status, 8'h01);
    chk(disc_status, 8'h01);
    $display("test reset done");
    vsc_plc_model_i.put(1'b1, 8'h17);
    tick(5);
    chk(model, 4'hb);
    chk(fb_status, 8'h01);
    wait_sts(1, 1'b1);
    chk(k > 10, 1'b1);
    chk(fb_status, 8'h03);
    chk(n_load, 1);
    load_done = 1'b1;
    tick(1);
    load_done = 1'b0;
    wait_sts(2, 1'b1);
    chk(disc_status, 8'h07);
    stop = 1'b1;
    wait_sts(2, 1'b0);
    stop = 1'b0;
    wait_sts(2, 1'b1);
    $display("test switchover done");
    vsc_plc_model_i.put(1'b1, 8'h01);
    tick(6);
    chk(model, 4'hb);
    vsc_plc_model_i.put(1'b1, 8'h06);
    tick(6);
    chk(model, 4'hb);
    vsc_plc_model_i.put(1'b0, 8'h06);
    tick(6);
    chk(model, 4'hb);
    vsc_plc_model_i.put(1'b0, 8'h07);
    tick(6);
    chk(model, 4'h3);
    tick(30);
    chk(fb_status, 8'h01);
    keypad_valid = 1'b1;
    tick(1);
    keypad_valid = 1'b0;
    tick(6);
    chk(model, 4'h3);
    vsc_plc_model_i.put(1'b0, 8'h00);
    tick(3);
    keypad_valid = 1'b1;
    tick(1);
    keypad_valid = 1'b0;
    tick(6);
    chk(model, 4'h9);
    vsc_plc_model_i.put(1'b1, 8'h37);
    tick(6);
    chk(model, 4'hb);
    $display("test selection done");
    for (int i = 0; i < 2; i++) begin
      vsc_plc_model_i.put(i[0], 8'h40);
      cnt(0);
      chk(n, 1);
      err_ev = 1'b1;
      tick(1);
      err_ev = 1'b0;
      tick(3);
      chk(fb_status[0], 1'b0);
      vsc_plc_model_i.put(i[0], 8'h80);
      cnt(1);
      chk(n, 1);
      chk(fb_status[0], 1'b1);
    end
    vsc_plc_model_i.put(1'b1, 8'h20);
    cnt(0);
    chk(n, 0);
    $display("test commands done");
    good = 1'b1;
    tick(1);
    good = 1'b0;
    cnt(2);
    chk(n, 5);
    bad = 1'b1;
    tick(1);
    bad = 1'b0;
    cnt(3);
    chk(n, 5);
    $display("test results done");
    for (int i = 6; i < 11; i++) vsc_plc_model_i.wr(8'(i), 8'(i * 17));
    chk(tdelay, 32'h66778899);
    snd_wr = 1'b1;
    for (int i = 31; i < 33; i++) begin
      snd_addr = 8'(i);
      snd_data = 8'hc3;
      tick(1);
    end
    snd_wr = 1'b0;
    fb_rd_addr = 8'h1f;
    tick(2);
    chk(fb_rd_data, 8'hc3);
    fb_rd_addr = 8'h20;
    tick(2);
    chk(fb_rd_data, 8'h00);
    fb_rd_addr = 8'h00;
    tick(2);
    chk(fb_rd_data, 8'h00);
    chk(n_load, 2);
    $display("test data areas done");
    end_sim();
  end
endmodule : testbench
